/* logic/psec_event_counter.sv */
// Purpose: Saturating, clear-on-read event counter.
// Assumes: Increment and clear are one-cycle strobes on the same clock.
// Notes:   A clear that meets an increment leaves a count of one.
`timescale 1ns/100ps
module psec_event_counter
  import psec_pkg::*;
#(
  parameter int unsigned WIDTH = PSEC_CNT_W
)
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  input  wire logic             inc,
  input  wire logic             clr,
  output logic [WIDTH-1:0]      count
);

  localparam logic [WIDTH-1:0] CNT_MAX = {WIDTH{1'b1}};
  localparam logic [WIDTH-1:0] CNT_ONE = {{(WIDTH-1){1'b0}}, 1'b1};

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  // The reader already holds the old value, so the new event restarts the count.
  always_comb
  begin
    count_d = count_q;
    if (clr)
    begin
      count_d = inc ? CNT_ONE : '0; // [RULE_16]
    end
    else if (inc && (count_q != CNT_MAX)) // [RULE_08] [RULE_13]
    begin
      count_d = count_q + CNT_ONE;
    end
  end

  // State holds while the clock enable is low.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_q <= PSEC_CNT_RESET[WIDTH-1:0];
    end
    else if (ce)
    begin
      count_q <= count_d;
    end
  end

  assign count = count_q;

  // Checks on one counter; every instance carries its own copy of them.
  sat_hold_a:  assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_08] [RULE_13]
                 ce && !clr && count_q == CNT_MAX |=> count_q == CNT_MAX)
    else $error("Event tally wrapped past its maximum.");
  clr_zero_a:  assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_09]
                 ce && clr && !inc |=> count_q == '0)
    else $error("Event tally not cleared by its read.");
  race_keep_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_16]
                 ce && clr && inc |=> count_q == CNT_ONE)
    else $error("Event lost at the clearing read.");

endmodule

/* logic/psec_pkg.sv */
// Purpose: Shared constants for the PHY status and error counter register bank.
// Assumes: AXI4-Lite with 32-bit data; one register per aligned word.
// Notes:   Register indices are word numbers; the byte address is four times the index.
package psec_pkg;

  // Address decode width: word index taken from byte address bits [7:2].
  localparam int unsigned PSEC_ADDR_W  = 8;
  localparam int unsigned PSEC_IDX_W   = 6;

  // Word indices of the registers.
  localparam logic [5:0] PSEC_IDX_STATUS   = 6'h10;
  localparam logic [5:0] PSEC_IDX_IRQ_STAT = 6'h11;
  localparam logic [5:0] PSEC_IDX_IRQ_MASK = 6'h12;
  localparam logic [5:0] PSEC_IDX_FC_CNT   = 6'h14;
  localparam logic [5:0] PSEC_IDX_RX_CNT   = 6'h15;

  // Field positions of the combined PHY status register.
  localparam int unsigned PSEC_ST_LINK    = 0;
  localparam int unsigned PSEC_ST_SPEED10 = 1;
  localparam int unsigned PSEC_ST_DUPLEX  = 2;
  localparam int unsigned PSEC_ST_LOOP    = 3;
  localparam int unsigned PSEC_ST_ANEG    = 4;
  localparam int unsigned PSEC_ST_FC_LAT  = 11;
  localparam int unsigned PSEC_ST_RX_LAT  = 13;

  // Interrupt status and mask layout.
  localparam int unsigned PSEC_IRQ_W       = 3;
  localparam int unsigned PSEC_IRQ_FC      = 0;
  localparam int unsigned PSEC_IRQ_RX      = 1;
  localparam int unsigned PSEC_IRQ_LINK    = 2;

  // Counter geometry and reset values.
  localparam int unsigned PSEC_CNT_W       = 8;
  localparam logic [7:0]  PSEC_CNT_RESET   = 8'h00;
  localparam logic [2:0]  PSEC_IRQ_RESET   = 3'h0;

  // AXI responses.
  localparam logic [1:0]  PSEC_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  PSEC_RESP_SLVERR = 2'h2;

  // Word index of a byte address; shared by the read and write decoders.
  function automatic logic [5:0] psec_word_idx(input logic [7:0] addr);
    psec_word_idx = addr[7:2];
  endfunction

endpackage

/* logic/psec_top.sv */
// Purpose: PHY status word, false carrier and receive error counters over AXI4-Lite.
// Assumes: All PHY-side inputs come from logic on aclk; no synchronisers needed.
// Notes:   Reads have side effects, so a read is acted on once, at the address handshake.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps

// Function
// [RULE_01] Status bit 4 shows auto-negotiation complete.
// [RULE_02] Status bit 3 shows loopback enabled.
// [RULE_03] Status bit 2 shows full duplex.
// [RULE_04] Software trusts duplex only with valid link.
// [RULE_05] Status bit 1 shows 10 Mb/s speed.
// [RULE_06] Status bit 0 mirrors link, read never clears.
// [RULE_07] Counter bits 15:8 read zero, writes ignored.
// [RULE_08] False carrier tally counts events and saturates.
// [RULE_09] False carrier tally is read-only, cleared by read.
// [RULE_10] Receive error tally counts errored valid carriers.
// [RULE_11] At most one count per carrier event.
// [RULE_12] Carrier with collision never counts.
// [RULE_13] Receive error tally saturates until read.
// [RULE_14] Bit 13 latch set by receive error, read clears.
// [RULE_15] Bit 11 latch set by false carrier, read clears.
// [RULE_16] Event meeting clearing read is counted after clear.
module psec_top
  import psec_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // PHY-side status levels.
  input  wire logic        link_up,
  input  wire logic        speed_10,
  input  wire logic        full_duplex,
  input  wire logic        loopback_en,
  input  wire logic        aneg_complete,
  // PHY-side receive events.
  input  wire logic        false_carrier_evt,
  input  wire logic        carrier_sense,
  input  wire logic        symbol_err,
  input  wire logic        collision,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq
);

  logic                  awready_q;
  logic                  wready_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  arready_q;
  logic                  rvalid_q;
  logic [31:0]           rdata_q;
  logic [1:0]            rresp_q;
  logic                  irq_q;
  logic [7:0]            awaddr_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  carrier_q;
  logic                  err_seen_q;
  logic                  coll_seen_q;
  logic                  link_q;
  logic                  fc_latch_q;
  logic                  rx_latch_q;
  logic [PSEC_IRQ_W-1:0] irq_stat_q;
  logic [PSEC_IRQ_W-1:0] irq_mask_q;
  logic [PSEC_IRQ_W-1:0] irq_stat_d;
  logic [PSEC_IRQ_W-1:0] irq_set;
  logic [PSEC_IRQ_W-1:0] irq_w1c;
  logic [PSEC_CNT_W-1:0] false_carrier_tally;
  logic [PSEC_CNT_W-1:0] rx_symbol_error_tally;
  logic [31:0]           status_word;
  logic [31:0]           rd_word;
  logic [5:0]            rd_idx;
  logic [5:0]            wr_idx;
  logic                  rd_hit;
  logic                  wr_hit;
  logic                  ar_hs;
  logic                  wr_go;
  logic                  fc_clr;
  logic                  rx_clr;
  logic                  rx_inc;
  logic                  link_chg;

  // Handshake terms; a read acts only when the clock enable lets state move.
  assign ar_hs  = s_axi_arvalid && arready_q && ce;
  assign wr_go  = !awready_q && !wready_q && !bvalid_q && ce;
  assign rd_idx = psec_word_idx(s_axi_araddr);
  assign wr_idx = psec_word_idx(awaddr_q);
  assign fc_clr = ar_hs && (rd_idx == PSEC_IDX_FC_CNT); // [RULE_09]
  assign rx_clr = ar_hs && (rd_idx == PSEC_IDX_RX_CNT); // [RULE_13]

  // A receive error counts once, at the end of a carrier that saw an invalid
  // symbol and no collision; waiting for the end is what lets a late collision veto it.
  assign rx_inc = carrier_q && !carrier_sense && err_seen_q && !coll_seen_q; // [RULE_11] [RULE_12]
  assign link_chg = (link_q != link_up);

  // Per-carrier bookkeeping of invalid symbols and collisions.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      carrier_q   <= 1'b0;
      err_seen_q  <= 1'b0;
      coll_seen_q <= 1'b0;
    end
    else if (ce)
    begin
      carrier_q <= carrier_sense;
      if (carrier_sense && !carrier_q)
      begin
        err_seen_q  <= symbol_err; // [RULE_10]
        coll_seen_q <= collision; // [RULE_12]
      end
      else if (carrier_sense)
      begin
        err_seen_q  <= err_seen_q || symbol_err;
        coll_seen_q <= coll_seen_q || collision;
      end
    end
  end

  // Saturating clear-on-read counters.
  psec_event_counter #(
    .WIDTH (PSEC_CNT_W)
  ) u_fc_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .inc     (false_carrier_evt), // [RULE_08]
    .clr     (fc_clr),
    .count   (false_carrier_tally)
  );

  psec_event_counter #(
    .WIDTH (PSEC_CNT_W)
  ) u_rx_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .inc     (rx_inc), // [RULE_13]
    .clr     (rx_clr),
    .count   (rx_symbol_error_tally)
  );

  // Latch flags; a new event in the clearing cycle keeps the flag set.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fc_latch_q <= 1'b0;
      rx_latch_q <= 1'b0;
    end
    else if (ce)
    begin
      fc_latch_q <= false_carrier_evt || (fc_latch_q && !fc_clr); // [RULE_15]
      rx_latch_q <= rx_inc || (rx_latch_q && !rx_clr); // [RULE_14]
    end
  end

  // Combined status word, assembled live from the PHY levels and the two event latches.
  always_comb
  begin
    status_word                  = '0;
    status_word[PSEC_ST_LINK]    = link_up; // [RULE_06]
    status_word[PSEC_ST_SPEED10] = speed_10; // [RULE_05]
    status_word[PSEC_ST_DUPLEX]  = full_duplex; // [RULE_03]
    status_word[PSEC_ST_LOOP]    = loopback_en; // [RULE_02]
    status_word[PSEC_ST_ANEG]    = aneg_complete; // [RULE_01]
    status_word[PSEC_ST_FC_LAT]  = fc_latch_q; // [RULE_15]
    status_word[PSEC_ST_RX_LAT]  = rx_latch_q; // [RULE_14]
  end

  // Read multiplexer; counter upper bits are padded with zeros.
  always_comb
  begin
    rd_word = '0;
    rd_hit  = 1'b1;
    case (rd_idx)
      PSEC_IDX_STATUS:   rd_word = status_word;
      PSEC_IDX_IRQ_STAT: rd_word = {29'h0000000, irq_stat_q};
      PSEC_IDX_IRQ_MASK: rd_word = {29'h0000000, irq_mask_q};
      PSEC_IDX_FC_CNT:   rd_word = {24'h000000, false_carrier_tally}; // [RULE_07]
      PSEC_IDX_RX_CNT:   rd_word = {24'h000000, rx_symbol_error_tally}; // [RULE_07]
      default:           rd_hit  = 1'b0;
    endcase
  end

  // Write decode; counters and status accept writes but nothing changes.
  assign wr_hit = wr_idx inside {PSEC_IDX_STATUS, PSEC_IDX_IRQ_STAT, PSEC_IDX_IRQ_MASK,
                                 PSEC_IDX_FC_CNT, PSEC_IDX_RX_CNT}; // [RULE_07]

  // Read channel: one read in flight, answered the cycle after the address.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= PSEC_RESP_OKAY;
    end
    else if (ce)
    begin
      if (ar_hs)
      begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_word;
        rresp_q   <= rd_hit ? PSEC_RESP_OKAY : PSEC_RESP_SLVERR;
      end
      else if (rvalid_q && s_axi_rready)
      begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // Write address and data are caught independently, in either order.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && awready_q)
      begin
        awready_q <= 1'b0;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q)
      begin
        wready_q <= 1'b0;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (bvalid_q && s_axi_bready)
      begin
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // Write response, issued the cycle after both halves are held.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= PSEC_RESP_OKAY;
    end
    else if (ce)
    begin
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? PSEC_RESP_OKAY : PSEC_RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Interrupt sources and write-one-to-clear; only byte lane 0 carries bits.
  assign irq_set = {link_chg, rx_inc, false_carrier_evt};
  assign irq_w1c = (wr_go && (wr_idx == PSEC_IDX_IRQ_STAT) && wstrb_q[0]) ?
                   wdata_q[PSEC_IRQ_W-1:0] : '0;
  // Set wins over clear so an event in the clearing cycle survives.
  assign irq_stat_d = (irq_stat_q & ~irq_w1c) | irq_set;

  // Interrupt status, mask and output; irq lags the status by one cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat_q <= PSEC_IRQ_RESET;
      irq_mask_q <= PSEC_IRQ_RESET;
      irq_q      <= 1'b0;
      link_q     <= 1'b0;
    end
    else if (ce)
    begin
      irq_stat_q <= irq_stat_d;
      link_q     <= link_up;
      irq_q      <= |(irq_stat_q & irq_mask_q);
      if (wr_go && (wr_idx == PSEC_IDX_IRQ_MASK) && wstrb_q[0])
      begin
        irq_mask_q <= wdata_q[PSEC_IRQ_W-1:0];
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign irq           = irq_q;

  // Checks on the register contents and counting behaviour.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic st_rd;
  assign st_rd = ar_hs && (rd_idx == PSEC_IDX_STATUS);

  aneg_bit_a:   assert property (st_rd |=> rdata_q[4] == $past(aneg_complete)) // [RULE_01]
    else $error("Status bit 4 does not follow auto-negotiation.");
  loop_bit_a:   assert property (st_rd |=> rdata_q[3] == $past(loopback_en)) // [RULE_02]
    else $error("Status bit 3 does not follow loopback.");
  duplex_bit_a: assert property (st_rd |=> rdata_q[2] == $past(full_duplex)) // [RULE_03]
    else $error("Status bit 2 does not follow duplex.");
  speed_bit_a:  assert property (st_rd |=> rdata_q[1] == $past(speed_10)) // [RULE_05]
    else $error("Status bit 1 does not follow speed.");
  link_keep_a:  assert property (st_rd |=> rdata_q[0] == $past(link_up)) // [RULE_06]
    else $error("Status bit 0 does not mirror the link.");
  cnt_upper_a:  assert property ((fc_clr || rx_clr) |=> rdata_q[31:8] == 24'h000000) // [RULE_07]
    else $error("Counter upper bits are not zero.");
  fc_cor_a:     assert property (fc_clr && !false_carrier_evt // [RULE_09]
                                 |=> false_carrier_tally == 8'h00 &&
                                     rdata_q[7:0] == $past(false_carrier_tally))
    else $error("False carrier tally not cleared by read.");
  rx_once_a:    assert property (ce && rx_inc |=> !rx_inc) // [RULE_11]
    else $error("Receive error counted twice for one carrier.");
  rx_coll_a:    assert property (ce && carrier_sense && collision // [RULE_12]
                                 ##1 !carrier_sense |-> !rx_inc)
    else $error("Receive error counted despite collision.");
  rx_latch_a:   assert property (ce && rx_inc |=> rx_latch_q) // [RULE_14]
    else $error("Receive error latch not set.");
  fc_latch_a:   assert property (ce && fc_latch_q && fc_clr && !false_carrier_evt // [RULE_15]
                                 |=> !fc_latch_q)
    else $error("False carrier latch not cleared by read.");

  rd_fc_c:   cover property (fc_clr ##[1:8] s_axi_rvalid && s_axi_rready);
  rx_cnt_c:  cover property (rx_inc ##[1:50] rx_clr);
  irq_c:     cover property (!irq ##1 irq);
  race_c:    cover property (fc_clr && false_carrier_evt);

endmodule

/* verif/psec_mgmt_master.sv */
// Purpose: Management controller model that drives the AXI4-Lite register port.
// Assumes: The bench holds req until done; one transfer is open at a time.
// Notes:   It waits as long as the slave takes; only the bench bounds the wait.
`timescale 1ns/100ps
module psec_mgmt_master
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  output logic             done,
  output logic [31:0]      rd_data,
  output logic [1:0]       resp,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      m_wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] s_rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  logic busy_q;

  // Each channel holds valid and payload until its own ready edge.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {busy_q, done, awvalid, wvalid, bready, arvalid, rready} <= '0;
      {rd_data, resp, awaddr, m_wdata, araddr} <= '0;
      wstrb <= 4'hF;
    end
    else
    begin
      done <= 1'b0;
      // Done blocks a restart, since req is still high in that cycle.
      if (req && !busy_q && !done)
      begin
        busy_q <= 1'b1;
        awaddr <= addr;
        araddr <= addr;
        m_wdata <= wdata;
        {awvalid, wvalid, bready} <= {3{we}};
        {arvalid, rready} <= {2{!we}};
      end
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
      if (bvalid && bready)
      begin
        {bready, busy_q, done} <= 3'h1;
        resp <= bresp;
      end
      if (rvalid && rready)
      begin
        {rready, busy_q, done} <= 3'h1;
        resp <= rresp;
        rd_data <= s_rdata;
      end
    end
  end
endmodule

/* verif/test_psec_top.sv */
// Purpose: Self-checking bench for the status word and event counters.
// Assumes: ce is high except for one frozen stretch; PHY-side events are driven on aclk.
// Notes:   Addresses are four times the word index.
`timescale 1ns/100ps
module test_psec_top
  import psec_pkg::*;
;
  logic aclk, aresetn, ce, req, we, done, irq;
  logic link_up, speed_10, full_duplex, loopback_en, aneg_complete;
  logic false_carrier_evt, carrier_sense, symbol_err, collision;
  logic [7:0] addr, s_axi_awaddr, s_axi_araddr;
  logic [31:0] wdata, rd_data, s_axi_wdata, s_axi_rdata;
  logic [1:0] resp, s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int compares, miscompares, i;
  logic [7:0] pats [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h1F, 8'h00};

  psec_top i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .link_up(link_up),
    .speed_10(speed_10), .full_duplex(full_duplex), .loopback_en(loopback_en),
    .aneg_complete(aneg_complete), .false_carrier_evt(false_carrier_evt),
    .carrier_sense(carrier_sense), .symbol_err(symbol_err), .collision(collision),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

  psec_mgmt_master i_mgmt (.aclk(aclk), .aresetn(aresetn), .req(req), .we(we),
    .addr(addr), .wdata(wdata), .done(done), .rd_data(rd_data), .resp(resp),
    .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid), .awready(s_axi_awready),
    .m_wdata(s_axi_wdata), .wstrb(s_axi_wstrb), .wvalid(s_axi_wvalid),
    .wready(s_axi_wready), .bresp(s_axi_bresp), .bvalid(s_axi_bvalid),
    .bready(s_axi_bready), .araddr(s_axi_araddr), .arvalid(s_axi_arvalid),
    .arready(s_axi_arready), .s_rdata(s_axi_rdata), .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid), .rready(s_axi_rready));

  // Free-running 40 MHz clock.
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] ba(input logic [5:0] idx);
    return {idx, 2'h0};
  endfunction

  // One transfer; fc puts a false carrier pulse on the read address edge.
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [31:0] d,
                      input bit fc);
    int n;
    @(posedge aclk);
    req <= 1'b1;
    we <= w;
    addr <= ba(idx);
    wdata <= d;
    @(posedge aclk);
    if (fc) false_carrier_evt <= 1'b1;
    @(posedge aclk);
    false_carrier_evt <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 50)
    begin
      @(posedge aclk);
      n++;
    end
    req <= 1'b0;
    if (n == 50)
    begin
      miscompares++;
      end_of_test();
    end
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp,
                    input logic [1:0] r = PSEC_RESP_OKAY);
    xfer(1'b0, idx, 32'h0, 1'b0);
    check(rd_data, exp);
    check({30'h0, resp}, {30'h0, r});
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d,
                    input logic [1:0] r = PSEC_RESP_OKAY);
    xfer(1'b1, idx, d, 1'b0);
    check({30'h0, resp}, {30'h0, r});
  endtask

  // Separate one-cycle false carrier pulses.
  task automatic fcp(input int n);
    repeat (n)
    begin
      @(posedge aclk);
      false_carrier_evt <= 1'b1;
      @(posedge aclk);
      false_carrier_evt <= 1'b0;
    end
  endtask

  // One carrier event with errs symbol errors, collision held if col.
  task automatic carrier(input int errs, input logic col);
    @(posedge aclk);
    carrier_sense <= 1'b1;
    collision <= col;
    repeat (errs)
    begin
      @(posedge aclk);
      symbol_err <= 1'b1;
      @(posedge aclk);
      symbol_err <= 1'b0;
    end
    @(posedge aclk);
    {carrier_sense, collision} <= 2'h0;
    repeat (2) @(posedge aclk);
  endtask

  // Main sequence; inputs get values at time zero, reset spans 16 edges.
  initial
  begin
    {aresetn, req, we, addr, wdata, link_up, speed_10, full_duplex} = '0;
    {loopback_en, aneg_complete, false_carrier_evt, carrier_sense} = '0;
    {symbol_err, collision, compares, miscompares} = '0;
    ce = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(PSEC_IDX_STATUS, 32'h0);
    rd(PSEC_IDX_FC_CNT, 32'h0);
    rd(PSEC_IDX_RX_CNT, 32'h0);
    rd(PSEC_IDX_IRQ_MASK, 32'h0);
    $display("test reset done");
    // Pattern 1F shows duplex and speed together with link up and aneg done; 02 and 04 show them without link.
    for (i = 0; i < 7; i++)
    begin
      @(posedge aclk);
      {aneg_complete, loopback_en, full_duplex, speed_10, link_up} <= pats[i][4:0];
      rd(PSEC_IDX_STATUS, {24'h0, pats[i]});
      rd(PSEC_IDX_STATUS, {24'h0, pats[i]});
    end
    $display("test status done");
    fcp(3);
    rd(PSEC_IDX_STATUS, 32'h800);
    rd(PSEC_IDX_FC_CNT, 32'h3);
    rd(PSEC_IDX_FC_CNT, 32'h0);
    rd(PSEC_IDX_STATUS, 32'h0);
    wr(PSEC_IDX_FC_CNT, 32'hFFFF_FFFF);
    rd(PSEC_IDX_FC_CNT, 32'h0);
    fcp(2);
    xfer(1'b0, PSEC_IDX_FC_CNT, 32'h0, 1'b1);
    check(rd_data, 32'h2);
    rd(PSEC_IDX_STATUS, 32'h800);
    rd(PSEC_IDX_FC_CNT, 32'h1);
    fcp(300);
    rd(PSEC_IDX_FC_CNT, 32'hFF);
    // Events while the clock enable is low must leave no trace.
    ce <= 1'b0;
    fcp(2);
    ce <= 1'b1;
    rd(PSEC_IDX_FC_CNT, 32'h0);
    $display("test false carrier done");
    carrier(3, 1'b0);
    rd(PSEC_IDX_STATUS, 32'h2000);
    rd(PSEC_IDX_RX_CNT, 32'h1);
    rd(PSEC_IDX_STATUS, 32'h0);
    carrier(2, 1'b1);
    carrier(0, 1'b0);
    wr(PSEC_IDX_RX_CNT, 32'hFFFF);
    rd(PSEC_IDX_RX_CNT, 32'h0);
    repeat (260) carrier(1, 1'b0);
    rd(PSEC_IDX_RX_CNT, 32'hFF);
    rd(PSEC_IDX_RX_CNT, 32'h0);
    $display("test receive error done");
    wr(PSEC_IDX_IRQ_STAT, 32'h7);
    rd(PSEC_IDX_IRQ_STAT, 32'h0);
    wr(PSEC_IDX_IRQ_MASK, 32'h1);
    rd(PSEC_IDX_IRQ_MASK, 32'h1);
    check({31'h0, irq}, 32'h0);
    fcp(1);
    repeat (3) @(posedge aclk);
    check({31'h0, irq}, 32'h1);
    rd(PSEC_IDX_IRQ_STAT, 32'h1);
    wr(PSEC_IDX_IRQ_MASK, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(PSEC_IDX_IRQ_MASK, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(PSEC_IDX_IRQ_STAT, 32'h1);
    check({31'h0, irq}, 32'h0);
    rd(PSEC_IDX_IRQ_STAT, 32'h0);
    rd(6'h3F, 32'h0, PSEC_RESP_SLVERR);
    wr(6'h3F, 32'h1, PSEC_RESP_SLVERR);
    $display("test interrupt and decode done");
    end_of_test();
  end
endmodule
